// ===== pac_params.svh
// constants for the process alarm and contact monitor
// What this block does
// - four independent process alarm channels, each configured on its own
// - on above off: high alarm, set above on, clear below off
// - on below off: low alarm, set below on, clear above off
// - alarm sets only after its condition holds unbroken for delay seconds
// - alarms evaluate continuously, with no host attached
// - each channel shows live selected value and present alarm state
// - category picks gas analysis or sensor readings; source list follows category
// - status trigger watched only while enabled; disabled ones add nothing
// - each enabled status trigger routes to warning or fault by severity
// - three dry contacts, normal open or closed, active when departed
// - contact asserts only after staying in new state for delay seconds
// - six character name stored for each contact input
`ifndef PAC_PARAMS_SVH
`define PAC_PARAMS_SVH

// register indices on the plain register port
`define PAC_ADDR_ON_BASE     8'h00
`define PAC_ADDR_OFF_BASE    8'h04
`define PAC_ADDR_CFG_BASE    8'h08
`define PAC_ADDR_LIVE_BASE   8'h0C
`define PAC_ADDR_STATE       8'h10
`define PAC_ADDR_CON_NORMAL  8'h11
`define PAC_ADDR_CON_DLY     8'h12
`define PAC_ADDR_NAME_LO     8'h15
`define PAC_ADDR_NAME_HI     8'h18
`define PAC_ADDR_TRIG_EN     8'h1B
`define PAC_ADDR_TRIG_SEV    8'h1C
`define PAC_ADDR_IRQ_STAT    8'h1D
`define PAC_ADDR_IRQ_MASK    8'h1E

// field positions
`define PAC_CFG_CAT_BIT      0
`define PAC_CFG_SEL_LSB      4
`define PAC_CFG_DLY_LSB      16
`define PAC_ST_ALARM_LSB     0
`define PAC_ST_CON_LSB       4
`define PAC_ST_RAW_LSB       8
`define PAC_ST_WARN_BIT      12
`define PAC_ST_FAULT_BIT     13
`define PAC_IRQ_ALARM_LSB    0
`define PAC_IRQ_CON_LSB      4
`define PAC_IRQ_WARN_BIT     7
`define PAC_IRQ_FAULT_BIT    8

// counts and reset values
`define PAC_NUM_ALARMS       4
`define PAC_NUM_CONTACTS     3
`define PAC_NAME_W           48
`define PAC_IRQ_W            9
`define PAC_RST_WORD         32'h0000_0000

`endif

// ===== pac_pkg.sv
// types shared by the process alarm and contact monitor
package pac_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [31:0] pac_word_t;
  typedef logic [7:0]  pac_addr_t;
  typedef enum logic {
    gas_analysis_category,
    sensor_reading_category
  } pac_cat_t;
endpackage

// ===== pac_monitor.sv
// process alarm channels, dry contact inputs and status trigger routing
//
// The register addresses and strobed register access were chosen for this implementation.
`include "pac_params.svh"

module pac_monitor #(
  parameter int VAL_W = 16,
  parameter int NSRC  = 8,
  parameter int NSTAT = 8,
  parameter int DLY_W = 16
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     resetn_in,
  input  wire logic                     clk_en_in,
  input  wire logic                     sec_tick_in,
  input  wire logic [NSRC*VAL_W-1:0]    gas_values_in,
  input  wire logic [NSRC*VAL_W-1:0]    sensor_values_in,
  input  wire logic [2:0]               contact_raw_in,
  input  wire logic [NSTAT-1:0]         status_cond_in,
  input  wire pac_pkg::pac_addr_t       reg_addr_in,
  input  wire pac_pkg::pac_word_t       reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output pac_pkg::pac_word_t            reg_rdata_out,
  output logic [3:0]                    alarm_out,
  output logic [2:0]                    contact_active_out,
  output logic                          warning_out,
  output logic                          fault_out,
  output logic                          irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pac_pkg::*;

  localparam int NA    = `PAC_NUM_ALARMS;
  localparam int NC    = `PAC_NUM_CONTACTS;
  localparam int SEL_W = (NSRC > 1) ? $clog2(NSRC) : 1;
  localparam int IRQ_W = `PAC_IRQ_W;

  // pick one source out of a packed bank
  function automatic logic signed [VAL_W-1:0] pick(
    input logic [NSRC*VAL_W-1:0] bank,
    input logic [SEL_W-1:0]      sel
  );
    pick = bank[sel*VAL_W +: VAL_W];
  endfunction

  // strict crossing test, direction chosen by the caller
  function automatic logic beyond(
    input logic signed [VAL_W-1:0] val,
    input logic signed [VAL_W-1:0] thr,
    input logic                    above
  );
    beyond = above ? (val > thr) : (val < thr);
  endfunction

  // seconds counter: counts ticks while the condition lasts, zero when it lapses
  // saturating, so a condition held for ages never wraps below the delay
  function automatic logic [DLY_W-1:0] step(
    input logic [DLY_W-1:0] cnt,
    input logic             hold,
    input logic             tick
  );
    if (!hold) begin
      step = '0;
    end else if (tick && (cnt != {DLY_W{1'b1}})) begin
      step = cnt + 1'b1;
    end else begin
      step = cnt;
    end
  endfunction

  // sign extension to a bus word
  function automatic pac_word_t sext(input logic signed [VAL_W-1:0] v);
    sext = {{(32-VAL_W){v[VAL_W-1]}}, v};
  endfunction

  // alarm channel state
  logic signed [VAL_W-1:0] on_reg   [NA];
  logic signed [VAL_W-1:0] off_reg  [NA];
  logic signed [VAL_W-1:0] live_reg [NA];
  pac_cat_t                cat_reg  [NA];
  logic [SEL_W-1:0]        sel_reg  [NA];
  logic [DLY_W-1:0]        adly_reg [NA];
  logic [DLY_W-1:0]        acnt_reg [NA];
  logic [NA-1:0]           alarm_reg;

  // contact state
  // two flops: contact levels are asynchronous to the system clock
  logic [NC-1:0]           sync1_reg;
  logic [NC-1:0]           sync2_reg;
  logic [NC-1:0]           normal_reg;
  logic [DLY_W-1:0]        cdly_reg [NC];
  logic [DLY_W-1:0]        ccnt_reg [NC];
  logic [NC-1:0]           cact_reg;
  logic [`PAC_NAME_W-1:0]  name_reg [NC];

  // status triggers, interrupt, bus
  logic [NSTAT-1:0]        trig_en_reg;
  logic [NSTAT-1:0]        trig_sev_reg;
  logic                    warn_reg;
  logic                    fault_reg;
  logic [IRQ_W-1:0]        irq_stat_reg;
  logic [IRQ_W-1:0]        irq_mask_reg;
  pac_word_t               rdata_reg;

  // combinational per-channel terms
  logic signed [VAL_W-1:0] sel_val   [NA];
  logic [NA-1:0]           is_high;
  logic [NA-1:0]           cond_on;
  logic [NA-1:0]           cond_off;
  logic [NA-1:0]           alarm_next;
  logic [DLY_W-1:0]        acnt_next [NA];
  logic [NA-1:0]           wr_on;
  logic [NA-1:0]           wr_off;
  logic [NA-1:0]           wr_cfg;
  logic [NC-1:0]           con_dep;
  logic [NC-1:0]           cact_next;
  logic [DLY_W-1:0]        ccnt_next [NC];
  logic [NC-1:0]           wr_cdly;
  logic [NC-1:0]           wr_nlo;
  logic [NC-1:0]           wr_nhi;

  genvar i;
  generate
    for (i = 0; i < NA; i++) begin : g_alarm
      // category decides which bank the selector indexes
      assign sel_val[i] = (cat_reg[i] == sensor_reading_category) ?
                          pick(sensor_values_in, sel_reg[i]) :
                          pick(gas_values_in, sel_reg[i]);
      // equal thresholds fall into low-limit mode
      assign is_high[i]  = on_reg[i] > off_reg[i];
      assign cond_on[i]  = beyond(sel_val[i], on_reg[i], is_high[i]);
      assign cond_off[i] = beyond(sel_val[i], off_reg[i], !is_high[i]);
      // the count only runs while idle and the set condition holds
      assign acnt_next[i] = step(acnt_reg[i], !alarm_reg[i] && cond_on[i],
                                 sec_tick_in);
      // clearing ignores the delay: an off crossing drops the alarm at once
      assign alarm_next[i] = alarm_reg[i] ? !cond_off[i] :
                             (cond_on[i] && (acnt_reg[i] >= adly_reg[i]));
      assign wr_on[i]  = reg_wr_in && (reg_addr_in == `PAC_ADDR_ON_BASE + 8'(i));
      assign wr_off[i] = reg_wr_in && (reg_addr_in == `PAC_ADDR_OFF_BASE + 8'(i));
      assign wr_cfg[i] = reg_wr_in && (reg_addr_in == `PAC_ADDR_CFG_BASE + 8'(i));
    end
    for (i = 0; i < NC; i++) begin : g_contact
      assign con_dep[i]   = sync2_reg[i] ^ normal_reg[i];
      assign ccnt_next[i] = step(ccnt_reg[i], con_dep[i], sec_tick_in);
      // a contact back in its normal state is inactive at once
      assign cact_next[i] = con_dep[i] && (ccnt_reg[i] >= cdly_reg[i]);
      assign wr_cdly[i] = reg_wr_in && (reg_addr_in == `PAC_ADDR_CON_DLY + 8'(i));
      assign wr_nlo[i]  = reg_wr_in && (reg_addr_in == `PAC_ADDR_NAME_LO + 8'(i));
      assign wr_nhi[i]  = reg_wr_in && (reg_addr_in == `PAC_ADDR_NAME_HI + 8'(i));
    end
  endgenerate

  // status trigger routing
  wire [NSTAT-1:0] trig_live  = status_cond_in & trig_en_reg;
  wire             warn_next  = |(trig_live & ~trig_sev_reg);
  wire             fault_next = |(trig_live & trig_sev_reg);

  // interrupt events: rising edges of every indication
  // layout: [3:0] alarms, [6:4] contacts, [7] warning, [8] fault
  wire [NA-1:0]    alarm_rise = alarm_next & ~alarm_reg;
  wire [NC-1:0]    con_rise   = cact_next & ~cact_reg;
  wire             warn_rise  = warn_next & ~warn_reg;
  wire             fault_rise = fault_next & ~fault_reg;
  wire [IRQ_W-1:0] irq_evt    = {fault_rise, warn_rise, con_rise, alarm_rise};
  // unmapped indices match no decode, so such writes change nothing
  wire             wr_irq_stat = reg_wr_in && (reg_addr_in == `PAC_ADDR_IRQ_STAT);
  wire             wr_irq_mask = reg_wr_in && (reg_addr_in == `PAC_ADDR_IRQ_MASK);
  wire             wr_trig_en  = reg_wr_in && (reg_addr_in == `PAC_ADDR_TRIG_EN);
  wire             wr_trig_sev = reg_wr_in && (reg_addr_in == `PAC_ADDR_TRIG_SEV);
  wire             wr_normal   = reg_wr_in && (reg_addr_in == `PAC_ADDR_CON_NORMAL);
  wire [IRQ_W-1:0] irq_clr     = wr_irq_stat ? reg_wdata_in[IRQ_W-1:0] : '0;
  // a new event in the clearing cycle survives the write-one-to-clear
  wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;

  wire pac_word_t state_word = pac_word_t'({fault_reg, warn_reg, 1'b0, sync2_reg,
                                            1'b0, cact_reg, alarm_reg});

  // read selection; unmapped indices read as zero
  pac_word_t rd_mux;
  always_comb begin
    rd_mux = `PAC_RST_WORD;
    for (int k = 0; k < NA; k++) begin
      if (reg_addr_in == `PAC_ADDR_ON_BASE + 8'(k)) begin
        rd_mux = sext(on_reg[k]);
      end
      if (reg_addr_in == `PAC_ADDR_OFF_BASE + 8'(k)) begin
        rd_mux = sext(off_reg[k]);
      end
      if (reg_addr_in == `PAC_ADDR_CFG_BASE + 8'(k)) begin
        rd_mux[`PAC_CFG_CAT_BIT] = cat_reg[k];
        rd_mux[`PAC_CFG_SEL_LSB +: SEL_W] = sel_reg[k];
        rd_mux[`PAC_CFG_DLY_LSB +: DLY_W] = adly_reg[k];
      end
      if (reg_addr_in == `PAC_ADDR_LIVE_BASE + 8'(k)) begin
        rd_mux = sext(live_reg[k]);
      end
    end
    for (int k = 0; k < NC; k++) begin
      if (reg_addr_in == `PAC_ADDR_CON_DLY + 8'(k)) begin
        rd_mux[DLY_W-1:0] = cdly_reg[k];
      end
      if (reg_addr_in == `PAC_ADDR_NAME_LO + 8'(k)) begin
        rd_mux = name_reg[k][31:0];
      end
      if (reg_addr_in == `PAC_ADDR_NAME_HI + 8'(k)) begin
        rd_mux[15:0] = name_reg[k][47:32];
      end
    end
    if (reg_addr_in == `PAC_ADDR_STATE) begin
      rd_mux = state_word;
    end
    if (reg_addr_in == `PAC_ADDR_CON_NORMAL) begin
      rd_mux[NC-1:0] = normal_reg;
    end
    if (reg_addr_in == `PAC_ADDR_TRIG_EN) begin
      rd_mux[NSTAT-1:0] = trig_en_reg;
    end
    if (reg_addr_in == `PAC_ADDR_TRIG_SEV) begin
      rd_mux[NSTAT-1:0] = trig_sev_reg;
    end
    if (reg_addr_in == `PAC_ADDR_IRQ_STAT) begin
      rd_mux[IRQ_W-1:0] = irq_stat_reg;
    end
    if (reg_addr_in == `PAC_ADDR_IRQ_MASK) begin
      rd_mux[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // alarm channels: evaluation never waits on host activity
  // the live copy gives software a settled snapshot of the selected source
  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < NA; k++) begin
      if (!resetn_in) begin
        acnt_reg[k] <= '0;
        live_reg[k] <= '0;
      end else if (clk_en_in) begin
        acnt_reg[k] <= acnt_next[k];
        live_reg[k] <= sel_val[k];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      alarm_reg <= '0;
      cact_reg  <= '0;
      sync1_reg <= '0;
      sync2_reg <= '0;
      warn_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end else if (clk_en_in) begin
      alarm_reg <= alarm_next;
      cact_reg  <= cact_next;
      sync1_reg <= contact_raw_in;
      sync2_reg <= sync1_reg;
      warn_reg  <= warn_next;
      fault_reg <= fault_next;
    end
  end

  // contacts: delay counters and stored names
  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < NC; k++) begin
      if (!resetn_in) begin
        ccnt_reg[k] <= '0;
        cdly_reg[k] <= '0;
        name_reg[k] <= '0;
      end else if (clk_en_in) begin
        ccnt_reg[k] <= ccnt_next[k];
        if (wr_cdly[k]) begin
          cdly_reg[k] <= reg_wdata_in[DLY_W-1:0];
        end
        if (wr_nlo[k]) begin
          name_reg[k][31:0] <= reg_wdata_in;
        end
        if (wr_nhi[k]) begin
          name_reg[k][47:32] <= reg_wdata_in[15:0];
        end
      end
    end
  end

  // alarm configuration; a new threshold takes effect on the next cycle
  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < NA; k++) begin
      if (!resetn_in) begin
        on_reg[k]   <= '0;
        off_reg[k]  <= '0;
        cat_reg[k]  <= gas_analysis_category;
        sel_reg[k]  <= '0;
        adly_reg[k] <= '0;
      end else if (clk_en_in) begin
        if (wr_on[k]) begin
          on_reg[k] <= reg_wdata_in[VAL_W-1:0];
        end
        if (wr_off[k]) begin
          off_reg[k] <= reg_wdata_in[VAL_W-1:0];
        end
        if (wr_cfg[k]) begin
          cat_reg[k]  <= pac_cat_t'(reg_wdata_in[`PAC_CFG_CAT_BIT]);
          sel_reg[k]  <= reg_wdata_in[`PAC_CFG_SEL_LSB +: SEL_W];
          adly_reg[k] <= reg_wdata_in[`PAC_CFG_DLY_LSB +: DLY_W];
        end
      end
    end
  end

  // global control registers, interrupt and read data
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      normal_reg   <= '0;
      trig_en_reg  <= '0;
      trig_sev_reg <= '0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      rdata_reg    <= `PAC_RST_WORD;
    end else if (clk_en_in) begin
      if (wr_normal) begin
        normal_reg <= reg_wdata_in[NC-1:0];
      end
      if (wr_trig_en) begin
        trig_en_reg <= reg_wdata_in[NSTAT-1:0];
      end
      if (wr_trig_sev) begin
        trig_sev_reg <= reg_wdata_in[NSTAT-1:0];
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= reg_wdata_in[IRQ_W-1:0];
      end
      irq_stat_reg <= irq_stat_next;
      // read data stands for its one answer cycle, then drops back to zero
      rdata_reg    <= reg_rd_in ? rd_mux : `PAC_RST_WORD;
    end
  end

  assign reg_rdata_out      = rdata_reg;
  assign alarm_out          = alarm_reg;
  assign contact_active_out = cact_reg;
  assign warning_out        = warn_reg;
  assign fault_out          = fault_reg;
  assign irq_out            = |(irq_stat_reg & irq_mask_reg);
endmodule

// ===== pac_monitor_asserts.sv
// port checker for the process alarm and contact monitor
module pac_monitor_chk #(
  parameter int NSTAT = 8
) (
  input wire logic               clk_sys_in,
  input wire logic               resetn_in,
  input wire logic               clk_en_in,
  input wire pac_pkg::pac_addr_t reg_addr_in,
  input wire logic               reg_rd_in,
  input wire logic               reg_wr_in,
  input wire logic [NSTAT-1:0]   status_cond_in,
  input wire pac_pkg::pac_word_t reg_rdata_out,
  input wire logic [3:0]         alarm_out,
  input wire logic [2:0]         contact_active_out,
  input wire logic               warning_out,
  input wire logic               fault_out,
  input wire logic               irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pac_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  property p_rd_idle;
    $past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    clk_en_in && reg_rd_in && reg_addr_in > 8'h1E |=> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_quiet;
    !$past(resetn_in) |-> alarm_out == 4'h0 && contact_active_out == 3'h0
      && !warning_out && !fault_out && !irq_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_no_cond;
    $past(clk_en_in) && !$past(status_cond_in) |-> !warning_out && !fault_out;
  endproperty
  a_no_cond: assert property (p_no_cond) else $error("indication without condition");
  property p_one_route;
    $past(clk_en_in) && $onehot($past(status_cond_in)) |-> !(warning_out && fault_out);
  endproperty
  a_one_route: assert property (p_one_route) else $error("one condition on both outputs");
  property p_freeze;
    !clk_en_in |=> $stable(alarm_out) && $stable(contact_active_out)
      && $stable(warning_out) && $stable(fault_out) && $stable(reg_rdata_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_irq_fall;
    $fell(irq_out) |-> $past(reg_wr_in);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
  property p_warn_src;
    $rose(warning_out) || $rose(fault_out) |-> $past(status_cond_in) != 0;
  endproperty
  a_warn_src: assert property (p_warn_src) else $error("indication rose with no cause");
endmodule

bind pac_monitor pac_monitor_chk #(.NSTAT(NSTAT)) pac_monitor_chk_i (.clk_sys_in, .resetn_in,
  .clk_en_in, .reg_addr_in, .reg_rd_in, .reg_wr_in, .status_cond_in, .reg_rdata_out,
  .alarm_out, .contact_active_out, .warning_out, .fault_out, .irq_out);

// ===== pac_field.sv
// partner model: process values, dry contacts, status conditions, seconds tick
module pac_field #(
  parameter int TICK = 20
) (
  input  wire logic         clk_sys_in,
  output logic      [127:0] gas_out,
  output logic      [127:0] sensor_out,
  output logic      [2:0]   contact_out,
  output logic      [7:0]   cond_out,
  output logic              tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // tick shortened from a real second so delay tests stay short
  initial begin
    gas_out = 128'h0;
    sensor_out = 128'h0;
    contact_out = 3'h0;
    cond_out = 8'h00;
    tick_out = 1'b0;
  end
  always @(posedge clk_sys_in) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    tick_out <= (cnt == TICK - 1);
  end
  task automatic set_val(input bit sen, input int s, input logic [15:0] v);
    if (sen) sensor_out[s*16 +: 16] <= v;
    else gas_out[s*16 +: 16] <= v;
  endtask
  task automatic set_con(input logic [2:0] c);
    contact_out <= c;
  endtask
  task automatic set_cond(input logic [7:0] c);
    cond_out <= c;
  endtask
endmodule

// ===== pac_monitor_bench.sv
// self-checking bench for the process alarm and contact monitor
module pac_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pac_pkg::*;
  logic         clk_sys_in = 1'b0, resetn_in = 1'b0, clk_en_in = 1'b1;
  logic         reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  pac_addr_t    reg_addr_in = 8'h00;
  pac_word_t    reg_wdata_in = 32'h0000_0000, reg_rdata_out;
  logic [127:0] gas_values_in, sensor_values_in;
  logic [2:0]   contact_raw_in, contact_active_out;
  logic [7:0]   status_cond_in, en, sev, cc;
  logic [3:0]   alarm_out;
  logic         sec_tick_in, warning_out, fault_out, irq_out;
  int           bad_count = 0, comparisons = 0, seed = 22;
  int           on, off, lo, hi;
  int           vs[3];
  bit           cur;
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  pac_field pac_field_i (.clk_sys_in(clk_sys_in), .gas_out(gas_values_in),
    .sensor_out(sensor_values_in), .contact_out(contact_raw_in),
    .cond_out(status_cond_in), .tick_out(sec_tick_in));
  pac_monitor pac_monitor_i (.clk_sys_in, .resetn_in, .clk_en_in, .sec_tick_in,
    .gas_values_in, .sensor_values_in, .contact_raw_in, .status_cond_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .alarm_out, .contact_active_out,
    .warning_out, .fault_out, .irq_out);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input pac_addr_t a, input pac_word_t d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input pac_addr_t a, input pac_word_t exp, input string what);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk(what, exp, reg_rdata_out);
  endtask
  task automatic val(input bit c, input int s, input int v);
    @(posedge clk_sys_in);
    pac_field_i.set_val(c, s, v[15:0]);
  endtask
  task automatic con(input logic [2:0] c);
    @(posedge clk_sys_in);
    pac_field_i.set_con(c);
  endtask
  task automatic cnd(input logic [7:0] c);
    @(posedge clk_sys_in);
    pac_field_i.set_cond(c);
  endtask
  task automatic sync();
    @(posedge clk_sys_in iff sec_tick_in);
  endtask
  // hysteresis model: order of on and off picks high or low limit
  function automatic bit alm(input int on, input int off, input int v, input bit cur);
    if (on > off) return v > on ? 1'b1 : (v < off ? 1'b0 : cur);
    return v < on ? 1'b1 : (v > off ? 1'b0 : cur);
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd(8'h08, 32'h0000_0000, "cfg reset");
    rd(8'h10, 32'h0000_0000, "state reset");
    rd(8'h40, 32'h0000_0000, "unmapped");
    for (int ch = 0; ch < 4; ch++) begin
      on = ch[0] ? -10 : 100;
      off = ch[0] ? 20 : 50;
      lo = ch[0] ? on : off;
      cur = 1'b0;
      vs = '{ch[0] ? -20 : 120, lo + 1 + ($unsigned($random(seed)) % 29), 30};
      wr(8'(ch), on);
      wr(8'(4 + ch), off);
      wr(8'(8 + ch), ((ch + 2) << 4) | ch[0]);
      val(!ch[0], ch + 2, 30);
      foreach (vs[i]) begin
        val(ch[0], ch + 2, vs[i]);
        step(4);
        cur = alm(on, off, vs[i], cur);
        chk("alarm", cur, alarm_out[ch]);
        rd(8'(12 + ch), vs[i], "live");
      end
    end
    wr(8'h08, 32'h0002_0020);
    sync();
    val(0, 2, 120);
    sync();
    step(3);
    chk("alarm", 0, alarm_out[0]);
    val(0, 2, 70);
    val(0, 2, 120);
    sync();
    step(3);
    chk("alarm", 0, alarm_out[0]);
    sync();
    step(3);
    chk("alarm", 1, alarm_out[0]);
    val(0, 2, 70);
    step(4);
    chk("alarm", 1, alarm_out[0]);
    val(0, 2, 30);
    step(4);
    chk("alarm", 0, alarm_out[0]);
    wr(8'h11, 32'h0000_0002);
    wr(8'h12, 32'h0000_0001);
    step(6);
    chk("contact", 2, contact_active_out);
    sync();
    con(3'b001);
    step(6);
    chk("contact", 2, contact_active_out);
    sync();
    step(3);
    chk("contact", 3, contact_active_out);
    con(3'b011);
    step(6);
    chk("contact", 1, contact_active_out);
    rd(8'h10, 32'h0000_0310, "state");
    for (int c = 0; c < 3; c++) begin
      lo = $random(seed);
      hi = $random(seed) & 32'h0000_FFFF;
      wr(8'(21 + c), lo);
      wr(8'(24 + c), hi);
      rd(8'(21 + c), lo, "name lo");
      rd(8'(24 + c), hi, "name hi");
    end
    repeat (8) begin
      en = 8'($random(seed));
      sev = 8'($random(seed));
      cc = 8'($random(seed));
      wr(8'h1B, en);
      wr(8'h1C, sev);
      cnd(cc);
      step(3);
      chk("warning", |(cc & en & ~sev), warning_out);
      chk("fault", |(cc & en & sev), fault_out);
    end
    wr(8'h1B, 32'h0000_00FF);
    wr(8'h1C, 32'h0000_0001);
    cnd(8'h01);
    step(3);
    chk("fault", 1, fault_out);
    @(posedge clk_sys_in) clk_en_in <= 1'b0;
    cnd(8'h02);
    step(4);
    chk("warning", 0, warning_out);
    @(posedge clk_sys_in) clk_en_in <= 1'b1;
    step(3);
    chk("warning", 1, warning_out);
    chk("fault", 0, fault_out);
    cnd(8'h00);
    rd(8'h1D, 32'h0000_01BF, "irq status all");
    wr(8'h1D, 32'h0000_01FF);
    wr(8'h1E, 32'h0000_0000);
    val(0, 4, 120);
    step(4);
    chk("irq", 0, irq_out);
    rd(8'h1D, 32'h0000_0004, "irq status");
    wr(8'h1E, 32'h0000_0004);
    step(1);
    chk("irq", 1, irq_out);
    wr(8'h1D, 32'h0000_0004);
    step(1);
    chk("irq", 0, irq_out);
    lo = $random(seed);
    wr(8'h03, lo);
    rd(8'h03, {{16{lo[15]}}, lo[15:0]}, "on threshold");
    summarize();
  end
endmodule
